// file: verilog/sleep_mode_controller.sv
/*
  Sleep mode controller: arms sleep from the control register, gates the
  clock domains on a sleep instruction and wakes the core on mode-dependent
  sources. Assumes wake sources come from other clock domains or pins and
  are synchronised here; the restart delay comes from the clock-select fuses.
  Assumes the core raises sleep_instr for the cycle in which it executes the
  sleep instruction and stops fetching while cpu_halted is high. Assumes the
  clock gates downstream act on the enables here without further delay, and
  that clk itself keeps running, since this block must see its wake sources.
*/
// The AHB-Lite interface to the registers and the address map were left to the implementer.
// What this block does
// - Sleep only when armed and sleep executed
// - Mode field bits three to one
// - Bits seven to four read zero
// - Interrupt wake halts four extra cycles
// - Register file and memory kept across sleep
// - Reset during sleep restarts at reset vector
// - Idle stops only CPU and flash clocks
// - Idle wakes on all interrupts
// - Power-down stops oscillator and generated clocks
// - Power-down wakes only on listed sources
// - Power-down wake waits fuse restart delay
// - Power-save equals power-down
// - Standby keeps oscillator, wakes in six cycles
// - Extended standby equals standby
// - USB wake irq wakes every mode
module sleep_mode_controller
  import sleep_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  input  wire logic        sleep_instr,
  input  wire logic        crystal_selected,
  input  wire logic [15:0] restart_delay_cycles,
  input  wire wake_src_t   wake_in,
  output clock_gate_t      clocks,
  output logic             cpu_halted,
  output logic             wake_irq_pending,
  output logic             wake_by_reset
);

  sleep_state_t state;
  wake_src_t    wake_meta;
  wake_src_t    wake_sync;
  logic [7:0]   sleep_control_reg;
  logic [2:0]   mode;
  logic [2:0]   sleep_mode;
  logic [15:0]  count;
  logic         wr_pending;
  logic         rd_pending;
  logic [31:0]  addr_q;
  logic         irq_wake;
  logic         reset_wake;
  logic         deep;

  // Wake terms split by whether they survive a stopped I/O clock.
  logic         upper_level_wake;
  logic         upper_edge_wake;
  logic         lower_wake;
  logic         async_wake;
  logic         clocked_wake;
  logic         bus_addr_phase;

  // A mode is accepted only if its code is defined; the standby pair also
  // needs the crystal, so a standby request with another clock source is
  // ignored rather than leaving the core asleep with nothing to wake it.

  function automatic logic mode_valid(input logic [2:0] m, input logic xtal);
    case (m)
      MODE_IDLE, MODE_POWER_DOWN, MODE_POWER_SAVE: mode_valid = 1'b1;
      MODE_STANDBY, MODE_EXT_STANDBY:              mode_valid = xtal;
      default:                                     mode_valid = 1'b0;
    endcase
  endfunction

  // The standby pair are the only deep modes in which the oscillator runs,
  // which is what buys them their short restart.
  function automatic logic keeps_osc(input logic [2:0] m);
    keeps_osc = (m == MODE_STANDBY) || (m == MODE_EXT_STANDBY);
  endfunction

  // The mode field is sampled at sleep entry and held in sleep_mode, so a
  // write during sleep cannot change how the block wakes.
  assign mode = sleep_control_reg[MODE_MSB:MODE_LSB];

  // Every wake source crosses two flops before any logic reads it.
  // This costs two cycles of wake latency but keeps a source that changes
  // near the clock edge from splitting the sequencer's decision. A level
  // source must therefore be held across at least one rising clock edge to be seen.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_meta <= '0;
      wake_sync <= '0;
    end else begin
      wake_meta <= wake_in;
      wake_sync <= wake_meta;
    end
  end

  // Any of the three reset sources wakes every mode and wins over an
  // interrupt that arrives in the same cycle.
  assign reset_wake = wake_sync.ext_reset | wake_sync.wdt_reset | wake_sync.bod_reset;
  assign deep       = (sleep_mode != MODE_IDLE);

  // Upper lines count in deep sleep only where set up as level interrupts:
  // their edge detectors run on the I/O clock, which is stopped there.
  assign upper_level_wake = |(wake_sync.upper_external_irq_lines & wake_sync.upper_level_mode);
  assign upper_edge_wake  = |wake_sync.upper_external_irq_lines;
  assign lower_wake       = |wake_sync.lower_external_irq_lines;

  // Sources that run without a generated clock and so work in every mode.
  assign async_wake = wake_sync.usb_wake_irq
                    | wake_sync.twi_addr_match
                    | lower_wake
                    | wake_sync.pin_change_irq
                    | upper_level_wake;

  // Sources that need the I/O clock and so are heard in idle only.
  assign clocked_wake = upper_edge_wake
                      | wake_sync.usb_sync_irq
                      | wake_sync.other_io_irq;

  // Power-save shares the power-down source set; the standby pair differs
  // from them only in the oscillator, so one deep set serves all four.
  always_comb begin
    if (deep) begin
      irq_wake = async_wake;
    end else begin
      irq_wake = async_wake | clocked_wake;
    end
  end

  // AHB-Lite slave with zero wait states; unmapped addresses read zero.
  // Every register answers in one cycle, so no wait state is ever needed
  // and no error response exists; hsize is ignored because each register
  // owns a whole word.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // An accepted address phase of either direction.
  assign bus_addr_phase = hready && hsel && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      addr_q     <= '0;
    end else if (hready) begin
      wr_pending <= bus_addr_phase && hwrite;
      rd_pending <= bus_addr_phase && !hwrite;
      addr_q     <= haddr;
    end
  end

  // Write data arrive in the data phase, one cycle after the address, so
  // the write lands at the end of that phase. The reserved upper nibble is
  // masked at the write so that it can never read back as one.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_control_reg <= SLEEP_CONTROL_RESET;
    end else if (wr_pending && addr_q == SLEEP_CONTROL_ADDR) begin
      sleep_control_reg <= hwdata[7:0] & CONTROL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= '0;
    // Read data are captured at the address phase and stand through the data
    // phase; a read right after a write to the same register sees the old
    // value because the write has not landed yet.
    end else if (bus_addr_phase && !hwrite) begin
      case (haddr)
        SLEEP_CONTROL_ADDR: hrdata <= {24'h00_0000, sleep_control_reg};
        SLEEP_STATUS_ADDR:  hrdata <= {26'h000_0000, wake_by_reset, wake_irq_pending,
                                       cpu_halted, sleep_mode};
        default:            hrdata <= '0;
      endcase
    end
  end

  // Sleep sequencer. The register file and memory are never touched here:
  // only clocks stop, so their contents survive any sleep period.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state            <= st_run;
      sleep_mode       <= MODE_IDLE;
      count            <= '0;
      wake_irq_pending <= 1'b0;
      wake_by_reset    <= 1'b0;
    end else begin
      case (state)
        // The arm bit is left as written: software is expected to clear it
        // after waking, and clearing it here would hide a missed clear.
        st_run: begin
          if (sleep_instr && sleep_control_reg[ARM_BIT]
              && mode_valid(mode, crystal_selected)) begin
            state            <= st_asleep;
            sleep_mode       <= mode;
            wake_irq_pending <= 1'b0;
            wake_by_reset    <= 1'b0;
          end
        end
        // The restart count is chosen by mode: idle keeps its clocks and
        // needs none, the standby pair has a running oscillator, and the
        // remaining deep modes wait out the fuse-selected start-up delay.
        st_asleep: begin
          if (reset_wake || irq_wake) begin
            wake_by_reset    <= reset_wake;
            wake_irq_pending <= !reset_wake;
            state            <= st_restart;
            if (!deep) begin
              count <= 16'h0000;
            end else if (keeps_osc(sleep_mode)) begin
              count <= STANDBY_WAKE_COUNT;
            end else begin
              count <= restart_delay_cycles;
            end
          end
        end
        // A count of zero or one both mean a single restart cycle, so a fuse
        // value of zero cannot wrap the counter into a long stall.
        st_restart: begin
          if (count > 16'h0001) begin
            count <= count - 16'h0001;
          end else if (wake_by_reset) begin
            state <= st_run;
          end else begin
            count <= {12'h000, IRQ_HALT_COUNT};
            state <= st_halt;
          end
        end
        // Interrupt wakes only: the core stays halted for the fixed extra
        // cycles before it may service the interrupt.
        st_halt: begin
          if (count > 16'h0001) begin
            count <= count - 16'h0001;
          end else begin
            state <= st_run;
          end
        end
        default: state <= st_run;
      endcase
    end
  end

  // The core is held through sleep, restart and the extra halt cycles.
  assign cpu_halted = (state != st_run);

  // Idle stops CPU and flash only; deeper modes also stop I/O, and the
  // oscillator stays on only in the standby pair. The I/O clock and oscillator
  // restart during the restart count so the oscillator can settle; CPU and flash stay gated until the core runs.
  always_comb begin
    clocks.cpu_clock_en   = 1'b1;
    clocks.flash_clock_en = 1'b1;
    clocks.io_clock_en    = 1'b1;
    clocks.osc_en         = 1'b1;
    if (state == st_asleep) begin
      clocks.cpu_clock_en   = 1'b0;
      clocks.flash_clock_en = 1'b0;
      if (deep) begin
        clocks.io_clock_en = 1'b0;
        clocks.osc_en      = keeps_osc(sleep_mode);
      end
    end else if (state != st_run) begin
      clocks.cpu_clock_en   = 1'b0;
      clocks.flash_clock_en = 1'b0;
    end
  end

endmodule // sleep_mode_controller

// file: verilog/sleep_pkg.sv
/*
  Package for the sleep mode controller: register map, field layout, mode
  codes, wake timing and the packed structs that carry grouped signals.
  Assumes a single 25 MHz system clock and an AHB-Lite register bus.
*/
package sleep_pkg;

  localparam logic [31:0] SLEEP_CONTROL_ADDR = 32'h0000_0000;
  localparam logic [31:0] SLEEP_STATUS_ADDR  = 32'h0000_0004;

  localparam int ARM_BIT  = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;

  localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK  = 8'h0f;

  localparam logic [2:0] MODE_IDLE       = 3'h0;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
  localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY    = 3'h6;
  localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

  localparam int          IRQ_HALT_CYCLES = 4;
  localparam logic [3:0]  IRQ_HALT_COUNT  = 4'(IRQ_HALT_CYCLES);
  localparam int          STANDBY_WAKE_CYCLES = 6;
  localparam logic [15:0] STANDBY_WAKE_COUNT  = 16'(STANDBY_WAKE_CYCLES);

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  typedef enum logic [2:0] {
    st_run,
    st_asleep,
    st_restart,
    st_halt
  } sleep_state_t;

  // Wake sources as they arrive at the controller, before its two-flop synchroniser.
  typedef struct packed {
    logic       ext_reset;
    logic       wdt_reset;
    logic       bod_reset;
    logic       twi_addr_match;
    logic [3:0] upper_external_irq_lines;
    logic [3:0] upper_level_mode;
    logic [3:0] lower_external_irq_lines;
    logic       pin_change_irq;
    logic       usb_wake_irq;
    logic       usb_sync_irq;
    logic       other_io_irq;
  } wake_src_t;

  typedef struct packed {
    logic cpu_clock_en;
    logic flash_clock_en;
    logic io_clock_en;
    logic osc_en;
  } clock_gate_t;

endpackage

// file: testbench/sleep_asserts.sv
/*
  Checker on the sleep controller ports.
  Assumes a restart delay of at most ten cycles.
*/
module sleep_asserts
  import sleep_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        sleep_instr,
  input wire wake_src_t   wake_in,
  input wire clock_gate_t clocks,
  input wire logic        cpu_halted,
  input wire logic        wake_by_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic listed;
  assign listed = wake_in.ext_reset | wake_in.wdt_reset | wake_in.bod_reset
    | wake_in.twi_addr_match | (|(wake_in.upper_external_irq_lines & wake_in.upper_level_mode))
    | (|wake_in.lower_external_irq_lines) | wake_in.pin_change_irq | wake_in.usb_wake_irq;
  property p_entry; !cpu_halted && !sleep_instr |=> !cpu_halted; endproperty
  a_entry: assert property (p_entry) else $error("halt without sleep");
  property p_run; !cpu_halted |-> clocks == 4'hf; endproperty
  a_run: assert property (p_run) else $error("clock gated while running");
  property p_gate; $rose(cpu_halted) |-> !clocks.cpu_clock_en && !clocks.flash_clock_en; endproperty
  a_gate: assert property (p_gate) else $error("core clocks run in sleep");
  property p_io; !clocks.osc_en |-> !clocks.io_clock_en; endproperty
  a_io: assert property (p_io) else $error("io clock without oscillator");
  property p_idle; cpu_halted && clocks.io_clock_en && wake_in.other_io_irq |-> ##[1:16] !cpu_halted;
  endproperty
  a_idle: assert property (p_idle) else $error("idle ignored interrupt");
  property p_deep;
    cpu_halted && !clocks.osc_en && !listed && !$past(listed) && !$past(listed, 2)
      && !$past(listed, 3) |=> cpu_halted;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep woke on wrong source");
  property p_stby; cpu_halted && clocks.osc_en && !clocks.io_clock_en && wake_in.usb_wake_irq
    |-> ##[1:16] !cpu_halted; endproperty
  a_stby: assert property (p_stby) else $error("usb wake ignored");
  property p_rst; cpu_halted && wake_in.ext_reset |-> ##[1:16] !cpu_halted; endproperty
  a_rst: assert property (p_rst) else $error("reset did not wake");
  c_sleep: cover property ($rose(cpu_halted));
  c_wake: cover property ($fell(cpu_halted));
  c_rwake: cover property ($rose(wake_by_reset));
endmodule // sleep_asserts

bind sleep_mode_controller sleep_asserts chk (.clk(clk), .reset_n(reset_n),
  .sleep_instr(sleep_instr), .wake_in(wake_in), .clocks(clocks), .cpu_halted(cpu_halted),
  .wake_by_reset(wake_by_reset));

// file: testbench/cpu_core_model.sv
/*
  Core model: turns a bench request into a one-cycle sleep instruction.
  Assumes software has armed the control register beforehand.
*/
module cpu_core_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic cpu_halted,
  output logic      sleep_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sleep_instr = 1'b0;
  // A halted core executes nothing, so no sleep request leaves it then.
  always @(posedge clk) sleep_instr <= go && !cpu_halted;
endmodule // cpu_core_model

// file: testbench/testbench.sv
/*
  Self-checking bench for the sleep mode controller.
  Assumes a zero-wait AHB-Lite slave and a restart delay of ten cycles.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_pkg::*;
  localparam int D = 10;
  logic        clk, reset_n, hsel, hwrite, go, sleep_instr, crystal, hreadyout;
  logic        cpu_halted, irq_pend, by_reset;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, hresp;
  wake_src_t   wake;
  clock_gate_t clocks;
  int          errors, total_checks, n;
  sleep_mode_controller dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_instr(sleep_instr),
    .crystal_selected(crystal), .restart_delay_cycles(16'(D)), .wake_in(wake),
    .clocks(clocks), .cpu_halted(cpu_halted), .wake_irq_pending(irq_pend),
    .wake_by_reset(by_reset));
  cpu_core_model core (.clk(clk), .go(go), .cpu_halted(cpu_halted), .sleep_instr(sleep_instr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic sleep(input logic [2:0] m, input logic arm);
    bus(1'b1, SLEEP_CONTROL_ADDR, {28'h0, m, arm});
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Counts edges from the wake stimulus until the core runs again.
  task automatic wake_up(input logic [19:0] p, input int exp);
    wake <= wake_src_t'(p);
    n = 0;
    while (cpu_halted !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    wake <= '0;
    chk(32'(n), 32'(exp));
  endtask
  task automatic t_regs;
    bus(1'b0, SLEEP_CONTROL_ADDR, 32'h0);
    chk(rd, {24'h0, SLEEP_CONTROL_RESET});
    bus(1'b1, SLEEP_CONTROL_ADDR, 32'hff);
    bus(1'b0, SLEEP_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0f);
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
    bus(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_refuse;
    logic [2:0] bad[4] = '{3'h1, 3'h4, 3'h5, MODE_STANDBY};
    sleep(MODE_IDLE, 1'b0);
    chk({31'h0, cpu_halted}, 32'h0);
    foreach (bad[i]) begin
      sleep(bad[i], 1'b1);
      chk({31'h0, cpu_halted}, 32'h0);
    end
  endtask
  task automatic t_idle;
    sleep(MODE_IDLE, 1'b1);
    chk({28'h0, clocks}, 32'h3);
    wake_up(20'h00001, 9);
    chk({31'h0, irq_pend}, 32'h1);
  endtask
  task automatic t_deep;
    logic [19:0] src[5] = '{20'h00010, 20'h01100, 20'h00008, 20'h10000, 20'h00004};
    foreach (src[i]) begin
      sleep(i[0] ? MODE_POWER_SAVE : MODE_POWER_DOWN, 1'b1);
      chk({28'h0, clocks}, 32'h0);
      wake <= wake_src_t'(20'h0f003);
      repeat (20) @(posedge clk);
      chk({31'h0, cpu_halted}, 32'h1);
      wake_up(src[i], 3 + D + IRQ_HALT_CYCLES + 1);
      bus(1'b0, SLEEP_CONTROL_ADDR, 32'h0);
      chk(rd, {28'h0, i[0] ? MODE_POWER_SAVE : MODE_POWER_DOWN, 1'b1});
    end
  endtask
  task automatic t_standby;
    crystal <= 1'b1;
    sleep(MODE_STANDBY, 1'b1);
    chk({28'h0, clocks}, 32'h1);
    wake_up(20'h00004, 3 + STANDBY_WAKE_CYCLES + IRQ_HALT_CYCLES + 1);
    sleep(MODE_EXT_STANDBY, 1'b1);
    chk({28'h0, clocks}, 32'h1);
    wake_up(20'h00004, 3 + STANDBY_WAKE_CYCLES + IRQ_HALT_CYCLES + 1);
  endtask
  task automatic t_reset;
    logic [19:0] src[3] = '{20'h80000, 20'h40000, 20'h20000};
    foreach (src[i]) begin
      sleep(MODE_POWER_DOWN, 1'b1);
      wake_up(src[i], 3 + D + 1);
      chk({31'h0, by_reset}, 32'h1);
      bus(1'b0, SLEEP_STATUS_ADDR, 32'h0);
      chk(rd, {26'h0, 1'b1, 1'b0, 1'b0, MODE_POWER_DOWN});
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    final_report;
  end
  initial begin
    {reset_n, hsel, hwrite, go, crystal, haddr, hwdata, htrans, wake} = '0;
    errors = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_refuse;
    t_idle;
    t_deep;
    t_standby;
    t_reset;
    final_report;
  end
endmodule // testbench
